// >>> core/cond_if.sv
// interface: condition flag register update bundle between top and flag modules
`timescale 1ns/10ps
interface cond_if;
    import status_cmd_pkg::*;
    logic [COND_W-1:0] live;       // live status this cycle
    logic [COND_W-1:0] gate;       // which live bits may set flags
    logic              clr;        // clear request pulse
    logic [COND_W-1:0] flags;      // sticky flags
    modport ctrl (output live, output gate, output clr, input flags);
    modport flag (input live, input gate, input clr, output flags);
endinterface : cond_if

// >>> core/status_aux_calib_cmd_handler.sv
// top: status, fault mask, aux outputs, restore and calibration command handler
//
// Operation
// - accumulated bit latches any live high
// - accumulated layout equals live layout
// - accumulated query clears after capture
// - reply value is summed bit weights
// - live query returns present conditions
// - fault query returns enabled latched faults
// - blocking command masks selected conditions
// - enabling command selects fault conditions
// - enable query returns enabled set
// - aux one set by arg, active low
// - aux one query returns stored setting
// - aux two set by arg, active low
// - aux two query returns stored setting
// - restore defaults and empty fault register
// - restore leaves calibration flag alone
// - local restore deferred until remote
// - calibration flag set/cleared by arg
// - calibration query returns flag
// - faults drive fault line; query clears
`timescale 1ns/10ps
module status_aux_calib_cmd_handler
    import status_cmd_pkg::*;
(
    input  wire logic              ref_clk,     // 100 MHz system clock
    input  wire logic              rstn,        // synchronous reset, active low
    input  wire logic [COND_W-1:0] cond_in,     // operating condition pins
    input  wire logic              remote_in,   // high when under remote control
    input  wire logic [ADDR_W-1:0] addr,        // register address
    input  wire logic [DATA_W-1:0] wdata,       // write data
    input  wire logic              wr,          // write strobe
    input  wire logic              rd,          // read strobe
    output logic      [DATA_W-1:0] rdata,       // read data, cycle after rd
    output logic                   reply_valid, // one-cycle pulse when reply updates
    output logic                   fault_out,   // high while any fault bit is set
    output logic                   aux_one_n,   // aux output one, active low
    output logic                   aux_two_n,   // aux output two, active low
    output logic                   cal_mode     // calibration mode flag
);

    // everything below runs on ref_clk alone; only the
    // condition pins and the remote level pass synchronisers

    // ---- input synchronisers: pins pass three flops ----
    logic [COND_W-1:0] cond_s1_ff;   // first stage, read only by stage two
    logic [COND_W-1:0] cond_s2_ff;
    logic [COND_W-1:0] cond_s3_ff;
    logic [COND_W-1:0] live_ff;      // live status register
    logic [COND_W-1:0] nxt_live;
    logic              rem_s1_ff;    // first stage, read only by stage two
    logic              rem_s2_ff;
    logic              rem_s3_ff;
    logic              remote_ff;    // filtered remote level
    logic              nxt_remote;

    // a one-cycle glitch never reaches the live register;
    // the price is about four cycles of latency

    // a bit changes only once stages two and three agree
    genvar gi;
    generate
        for (gi = 0; gi < COND_W; gi++) begin : g_cond_filt
            assign nxt_live[gi] = (cond_s2_ff[gi] == cond_s3_ff[gi]) ?
                                  cond_s2_ff[gi] : live_ff[gi];
        end
    endgenerate
    assign nxt_remote = (rem_s2_ff == rem_s3_ff) ? rem_s2_ff : remote_ff;

    // stage one feeds stage two only, so a metastable
    // value has a full cycle to settle
    // synchroniser and live status sampling, every cycle
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            cond_s1_ff <= FLAGS_RST;
            cond_s2_ff <= FLAGS_RST;
            cond_s3_ff <= FLAGS_RST;
            live_ff    <= FLAGS_RST;
            rem_s1_ff  <= 1'b0;
            rem_s2_ff  <= 1'b0;
            rem_s3_ff  <= 1'b0;
            remote_ff  <= 1'b0;
        end else begin
            cond_s1_ff <= cond_in;
            cond_s2_ff <= cond_s1_ff;
            cond_s3_ff <= cond_s2_ff;
            live_ff    <= nxt_live;
            rem_s1_ff  <= remote_in;
            rem_s2_ff  <= rem_s1_ff;
            rem_s3_ff  <= rem_s2_ff;
            remote_ff  <= nxt_remote;
        end
    end

    // ---- command decode ----
    // code in the low nibble, argument in the high byte;
    // a write to any other address is ignored

    logic [CMD_W-1:0]  cmd_code;      // command field of write data
    logic [7:0]        cmd_arg;       // argument field of write data
    logic              cmd_wr;        // write to command register
    logic              arg_on;        // argument nonzero means 1/ON
    cmd_state_t        state_ff;      // decoder state
    cmd_state_t        nxt_state;
    logic [CMD_W-1:0]  cmd_ff;        // latched command
    logic [7:0]        arg_ff;        // latched argument

    assign cmd_code = wdata[CMD_LSB +: CMD_W];
    assign cmd_arg  = wdata[ARG_LSB +: 8];
    assign cmd_wr   = wr && (addr == OFS_CMD);
    // any nonzero value as on avoids a third state
    // that every setting would have to refuse
    // host side maps ON to 1 and OFF to 0; any nonzero counts as on
    assign arg_on   = (arg_ff != 8'h00);

    // two states suffice: the port never stalls, so a
    // write during execution simply runs next cycle

    // one command latched, executed next cycle; a new write always restarts
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE: nxt_state = cmd_wr ? ST_EXEC : ST_IDLE;
            ST_EXEC: nxt_state = cmd_wr ? ST_EXEC : ST_IDLE;
            default: nxt_state = ST_IDLE;
        endcase
    end

    // exec is high for one cycle per accepted write
    logic              exec;          // latched command executes this cycle
    assign exec = (state_ff == ST_EXEC);

    // code and argument are latched together, so a
    // later strobe never pairs with a stale argument
    // command latch
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            state_ff <= ST_IDLE;
            cmd_ff   <= CMD_NONE;
            arg_ff   <= 8'h00;
        end else begin
            state_ff <= nxt_state;
            if (cmd_wr) begin
                cmd_ff <= cmd_code;
                arg_ff <= cmd_arg;
            end
        end
    end

    // ---- settings ----
    // a setting changes only when its own command
    // runs, or when a restore is applied
    logic [COND_W-1:0] enable_ff;     // conditions allowed to raise faults
    logic [COND_W-1:0] nxt_enable;
    logic              aux1_ff;       // stored aux one setting
    logic              nxt_aux1;
    logic              aux2_ff;       // stored aux two setting
    logic              nxt_aux2;
    logic              cal_ff;        // calibration mode flag
    logic              nxt_cal;
    logic              pend_ff;       // restore held back while local
    logic              nxt_pend;
    logic              do_restore;    // apply defaults this cycle
    logic              is_restore;    // restore command executing

    // under local control a restore only arms pend_ff;
    // defaults land on the first cycle of remote_ff high
    assign is_restore = exec && (cmd_ff == CMD_RESTORE);
    // local restore waits for remote; remote restore applies now
    assign do_restore = (is_restore && remote_ff) || (pend_ff && remote_ff);
    assign nxt_pend   = remote_ff ? 1'b0 : (pend_ff || is_restore);

    // a held-back restore that lands in the cycle of
    // another command wins; the host must resend that
    // command if it still wants it

    // setting update; a restore takes precedence over a command executing in the same cycle
    always_comb begin
        nxt_enable = enable_ff;
        nxt_aux1   = aux1_ff;
        nxt_aux2   = aux2_ff;
        nxt_cal    = cal_ff;
        if (do_restore) begin
            nxt_enable = ENABLE_RST;
            nxt_aux1   = AUX_RST;
            nxt_aux2   = AUX_RST;
            // calibration flag deliberately kept
        end else if (exec) begin
            case (cmd_ff)
                CMD_BLOCK:  nxt_enable = enable_ff & ~arg_ff;
                CMD_ENABLE: nxt_enable = arg_ff;
                CMD_AUX1:   nxt_aux1   = arg_on;
                CMD_AUX2:   nxt_aux2   = arg_on;
                CMD_CAL:    nxt_cal    = arg_on;
                default:    nxt_cal    = cal_ff;                 // others touch no setting
            endcase
        end
    end

    // plain flops with a synchronous reset; a restore also clears all but cal_ff
    // setting registers
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            enable_ff <= ENABLE_RST;
            aux1_ff   <= AUX_RST;
            aux2_ff   <= AUX_RST;
            cal_ff    <= CAL_RST;
            pend_ff   <= 1'b0;
        end else begin
            enable_ff <= nxt_enable;
            aux1_ff   <= nxt_aux1;
            aux2_ff   <= nxt_aux2;
            cal_ff    <= nxt_cal;
            pend_ff   <= nxt_pend;
        end
    end

    // ---- accumulated and fault flags ----
    // both registers share one sticky flag design and
    // differ only in gate mask and clear source;
    // accumulation is never masked, faults only if enabled

    cond_if acc_if ();                // accumulated status bundle
    cond_if flt_if ();                // fault register bundle

    logic              acc_clr;       // accumulated query clears
    logic              flt_clr;       // fault query or restore clears

    assign acc_clr     = exec && (cmd_ff == CMD_ACCUM_Q);
    assign flt_clr     = (exec && (cmd_ff == CMD_FAULT_Q)) || do_restore;
    // gating every bit on keeps the accumulated
    // layout equal to the live one bit for bit
    // same bit positions as the live register, every bit may accumulate
    assign acc_if.live = live_ff;
    assign acc_if.gate = {COND_W{1'b1}};
    assign acc_if.clr  = acc_clr;
    // only enabled conditions may latch faults
    assign flt_if.live = live_ff;
    assign flt_if.gate = enable_ff;
    assign flt_if.clr  = flt_clr;

    // accumulated status, cleared by its own query
    sticky_flags u_accum (
        .ref_clk (ref_clk),
        .rstn    (rstn),
        .cif     (acc_if.flag)
    );

    // fault register, cleared by its query or a restore
    sticky_flags u_fault (
        .ref_clk (ref_clk),
        .rstn    (rstn),
        .cif     (flt_if.flag)
    );

    // ---- reply ----
    // the reply is held in binary; the host side
    // turns it into the decimal text on the line

    logic [DATA_W-1:0] reply_ff;      // last reply value
    logic [DATA_W-1:0] nxt_reply;
    logic              rvalid_ff;     // reply updated pulse
    logic              nxt_rvalid;

    // only queries pulse reply_valid; set commands
    // leave the previous reply for a late reader
    // reply is the binary register value, i.e. the sum of set bit weights
    always_comb begin
        nxt_reply  = reply_ff;
        nxt_rvalid = 1'b0;
        if (exec) begin
            nxt_rvalid = 1'b1;
            case (cmd_ff)
                CMD_ACCUM_Q:  nxt_reply = {8'h00, acc_if.flags};
                CMD_LIVE_Q:   nxt_reply = {8'h00, live_ff};
                CMD_FAULT_Q:  nxt_reply = {8'h00, flt_if.flags};
                CMD_ENABLE_Q: nxt_reply = {8'h00, enable_ff};
                CMD_AUX1_Q:   nxt_reply = {15'h0000, aux1_ff};
                CMD_AUX2_Q:   nxt_reply = {15'h0000, aux2_ff};
                CMD_CAL_Q:    nxt_reply = {15'h0000, cal_ff};
                default:      nxt_rvalid = 1'b0;                 // set commands give no reply
            endcase
        end
    end

    // the reply stands until the next query
    // reply registers
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            reply_ff  <= DATA_RST;
            rvalid_ff <= 1'b0;
        end else begin
            reply_ff  <= nxt_reply;
            rvalid_ff <= nxt_rvalid;
        end
    end

    // ---- register read port ----
    // reads have no side effect, so polling the
    // state word never disturbs a flag

    logic [DATA_W-1:0] state_word;    // live state summary
    logic [DATA_W-1:0] rd_mux;        // selected read value
    logic [DATA_W-1:0] rdata_ff;

    assign state_word = {10'h000, rvalid_ff, fault_out, pend_ff, cal_ff, aux2_ff, aux1_ff};
    // unmapped addresses and the command register read as zero
    assign rd_mux = (addr == OFS_REPLY) ? reply_ff :
                    (addr == OFS_STATE) ? state_word : DATA_RST;

    // zero between reads keeps stale data off the bus
    // read data stands only in the cycle after the strobe
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            rdata_ff <= DATA_RST;
        end else begin
            rdata_ff <= rd ? rd_mux : DATA_RST;
        end
    end

    // ---- outputs ----
    // the fault line trails the fault register by one
    // cycle and drops once the fault query empties it

    logic fault_line_ff;              // registered fault line
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            fault_line_ff <= 1'b0;
        end else begin
            fault_line_ff <= (flt_if.flags != FLAGS_RST);
        end
    end

    // aux pins are active low: a stored 1 pulls down
    assign rdata       = rdata_ff;
    assign reply_valid = rvalid_ff;
    assign fault_out   = fault_line_ff;
    assign aux_one_n   = ~aux1_ff;
    assign aux_two_n   = ~aux2_ff;
    assign cal_mode    = cal_ff;

endmodule : status_aux_calib_cmd_handler

// >>> core/status_cmd_pkg.sv
// package: command codes, widths, defaults for the status/aux/calibration command handler
package status_cmd_pkg;

    localparam int           COND_W        = 8;       // number of operating condition bits
    localparam int           CMD_W         = 4;       // command code width
    localparam int           ADDR_W        = 4;       // register port address width
    localparam int           DATA_W        = 16;      // register port data width

    // command codes written to the command register
    localparam logic [CMD_W-1:0] CMD_NONE        = 4'h0;
    localparam logic [CMD_W-1:0] CMD_ACCUM_Q     = 4'h1;  // accum_status_query
    localparam logic [CMD_W-1:0] CMD_LIVE_Q      = 4'h2;  // live_status_query
    localparam logic [CMD_W-1:0] CMD_FAULT_Q     = 4'h3;  // fault query
    localparam logic [CMD_W-1:0] CMD_BLOCK       = 4'h4;  // condition blocking
    localparam logic [CMD_W-1:0] CMD_ENABLE      = 4'h5;  // condition_enable_cmd
    localparam logic [CMD_W-1:0] CMD_ENABLE_Q    = 4'h6;  // condition_enable_query
    localparam logic [CMD_W-1:0] CMD_AUX1        = 4'h7;  // aux_out_one
    localparam logic [CMD_W-1:0] CMD_AUX1_Q      = 4'h8;  // aux_out_one_query
    localparam logic [CMD_W-1:0] CMD_AUX2        = 4'h9;  // aux_out_two
    localparam logic [CMD_W-1:0] CMD_AUX2_Q      = 4'hA;  // aux_out_two_query
    localparam logic [CMD_W-1:0] CMD_RESTORE     = 4'hB;  // restore_defaults_cmd
    localparam logic [CMD_W-1:0] CMD_CAL         = 4'hC;  // calibration_flag_cmd
    localparam logic [CMD_W-1:0] CMD_CAL_Q       = 4'hD;  // calibration_flag_query

    // register port map
    localparam logic [ADDR_W-1:0] OFS_CMD        = 4'h0;  // write: cmd in [3:0], arg in [15:8]
    localparam logic [ADDR_W-1:0] OFS_REPLY      = 4'h1;  // read: last reply value
    localparam logic [ADDR_W-1:0] OFS_STATE      = 4'h2;  // read: live state summary

    // command register field positions
    localparam int           CMD_LSB       = 0;
    localparam int           ARG_LSB       = 8;

    // state summary field positions
    localparam int           ST_AUX1_BIT   = 0;
    localparam int           ST_AUX2_BIT   = 1;
    localparam int           ST_CAL_BIT    = 2;
    localparam int           ST_PEND_BIT   = 3;
    localparam int           ST_FAULT_BIT  = 4;
    localparam int           ST_VALID_BIT  = 5;

    // power-on values
    localparam logic [COND_W-1:0] ENABLE_RST  = 8'h00;
    localparam logic [COND_W-1:0] FLAGS_RST   = 8'h00;
    localparam logic              AUX_RST     = 1'b0;
    localparam logic              CAL_RST     = 1'b0;
    localparam logic [DATA_W-1:0] DATA_RST    = 16'h0000;

    // command decoder states
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_EXEC
    } cmd_state_t;

endpackage : status_cmd_pkg

// >>> core/sticky_flags.sv
// module: sticky flag register, set wins over clear
`timescale 1ns/10ps
module sticky_flags
    import status_cmd_pkg::*;
(
    input  wire logic ref_clk,
    input  wire logic rstn,
    cond_if.flag      cif
);
    logic [COND_W-1:0] flags_ff;     // held flags
    logic [COND_W-1:0] nxt_flags;    // next flag value
    logic [COND_W-1:0] set_bits;     // bits being set this cycle

    assign set_bits  = cif.live & cif.gate;
    // clear drops old bits only; a new set in the same cycle survives
    assign nxt_flags = (cif.clr ? {COND_W{1'b0}} : flags_ff) | set_bits;
    assign cif.flags = flags_ff;

    // flags update every cycle
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            flags_ff <= FLAGS_RST;
        end else begin
            flags_ff <= nxt_flags;
        end
    end
endmodule : sticky_flags

// >>> tb/host_model.sv
// partner: host side of the command port, issuing command writes and register reads
`timescale 1ns/10ps
module host_model
    import status_cmd_pkg::*;
(
    input  wire logic              ref_clk,
    output logic      [ADDR_W-1:0] addr,
    output logic      [DATA_W-1:0] wdata,
    output logic                   wr,
    output logic                   rd,
    input  wire logic [DATA_W-1:0] rdata
);
    // idle bus at time zero so no strobe is ever unknown
    initial begin
        addr  = 4'h0;
        wdata = 16'h0000;
        wr    = 1'b0;
        rd    = 1'b0;
    end
    // one write cycle; data are inverted afterwards so a stale value is never reused
    task automatic put(input logic [CMD_W-1:0] code, input logic [7:0] arg);
        @(posedge ref_clk);
        addr  <= OFS_CMD;
        wdata <= {arg, 4'h0, code};
        wr    <= 1'b1;
        @(posedge ref_clk);
        wr    <= 1'b0;
        wdata <= ~{arg, 4'h0, code};
    endtask : put
    // one read cycle; the answer is taken mid-cycle of the cycle after
    task automatic get(input logic [ADDR_W-1:0] ofs, output logic [DATA_W-1:0] val);
        @(posedge ref_clk);
        addr <= ofs;
        rd   <= 1'b1;
        @(posedge ref_clk);
        rd   <= 1'b0;
        @(negedge ref_clk);
        val = rdata;
        @(posedge ref_clk);
    endtask : get
endmodule : host_model

// >>> tb/status_aux_calib_cmd_handler_props.sv
// checker: port-level timing properties of the status, aux and calibration handler
`timescale 1ns/10ps
module status_aux_calib_cmd_handler_props
    import status_cmd_pkg::*;
(
    input wire logic              ref_clk,
    input wire logic              rstn,
    input wire logic [COND_W-1:0] cond_in,
    input wire logic              remote_in,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic              wr,
    input wire logic              rd,
    input wire logic [DATA_W-1:0] rdata,
    input wire logic              reply_valid,
    input wire logic              fault_out,
    input wire logic              aux_one_n,
    input wire logic              aux_two_n,
    input wire logic              cal_mode
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    wire             is_cmd    = wr && (addr == OFS_CMD);  // command write this cycle
    wire [CMD_W-1:0] code      = wdata[3:0];               // command code field
    wire             arg_on    = (wdata[15:8] != 8'h00);   // nonzero argument means on
    logic [3:0]      quiet_ff;                             // quiet cycles on cond_in, saturating
    // saturate so a long quiet spell never wraps back to "recent"
    wire  [3:0]      nxt_quiet = (cond_in != 8'h00) ? 4'h0 :
                                 (quiet_ff == 4'hF) ? 4'hF : quiet_ff + 4'h1;
    // quiet counter, cleared by reset so it starts pessimistic
    always_ff @(posedge ref_clk) begin
        quiet_ff <= !rstn ? 4'h0 : nxt_quiet;
    end
    chk_aux_one_on: assert property (
        is_cmd && code == CMD_AUX1 && arg_on |-> ##[1:2] !aux_one_n)
        else $error("aux one not driven low after on");
    chk_aux_one_off: assert property (
        is_cmd && code == CMD_AUX1 && !arg_on |-> ##[1:2] aux_one_n)
        else $error("aux one not released after off");
    chk_aux_two_on: assert property (
        is_cmd && code == CMD_AUX2 && arg_on |-> ##[1:2] !aux_two_n)
        else $error("aux two not driven low after on");
    chk_cal_flag_set: assert property (
        is_cmd && code == CMD_CAL && arg_on |-> ##[1:2] cal_mode)
        else $error("calibration flag not set");
    chk_cal_kept_restore: assert property (
        is_cmd && code == CMD_RESTORE |-> ##2 $stable(cal_mode))
        else $error("restore changed calibration flag");
    chk_rdata_idle_zero: assert property (!$past(rd) |-> rdata == 16'h0000)
        else $error("read data not zero outside read answer");
    chk_reply_has_cause: assert property (
        reply_valid |-> $past(is_cmd) || $past(is_cmd, 2) || $past(is_cmd, 3))
        else $error("reply pulse without a command");
    chk_fault_has_cause: assert property ($rose(fault_out) |-> quiet_ff < 4'hC)
        else $error("fault line rose with no recent condition");
    chk_fault_query_clr: assert property (
        is_cmd && code == CMD_FAULT_Q && quiet_ff == 4'hF |-> ##[2:4] !fault_out)
        else $error("fault line not released by fault query");
endmodule : status_aux_calib_cmd_handler_props

bind status_aux_calib_cmd_handler status_aux_calib_cmd_handler_props u_props (
    .ref_clk(ref_clk), .rstn(rstn), .cond_in(cond_in), .remote_in(remote_in),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .reply_valid(reply_valid), .fault_out(fault_out), .aux_one_n(aux_one_n),
    .aux_two_n(aux_two_n), .cal_mode(cal_mode));

// >>> tb/testbench.sv
// testbench: command sequences against the status, aux and calibration handler
`timescale 1ns/10ps
module testbench
    import status_cmd_pkg::*;
();
    logic              ref_clk;      // 100 MHz clock
    logic              rstn;         // synchronous reset, active low
    logic              remote_in;    // remote control level
    logic [COND_W-1:0] cond_in;      // condition pins
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
    logic [DATA_W-1:0] rdata;
    logic              reply_valid;
    logic              fault_out;
    logic              aux_one_n;
    logic              aux_two_n;
    logic              cal_mode;
    wire  [DATA_W-1:0] pins = {12'h0, fault_out, cal_mode, aux_two_n, aux_one_n};
    logic [DATA_W-1:0] rv;           // scratch read value
    int                failures;
    int                n_checks;
    // aux table: command, argument, expected {aux_two_n, aux_one_n}
    logic [CMD_W-1:0]  aux_cmd [4] = '{CMD_AUX1, CMD_AUX2, CMD_AUX1, CMD_AUX2};
    logic [7:0]        aux_arg [4] = '{8'h01, 8'hFF, 8'h00, 8'h00};
    logic [DATA_W-1:0] aux_pin [4] = '{16'h0002, 16'h0000, 16'h0001, 16'h0003};

    status_aux_calib_cmd_handler dut (.ref_clk(ref_clk), .rstn(rstn), .cond_in(cond_in),
        .remote_in(remote_in), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .reply_valid(reply_valid), .fault_out(fault_out),
        .aux_one_n(aux_one_n), .aux_two_n(aux_two_n), .cal_mode(cal_mode));
    host_model host (.ref_clk(ref_clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata));

    // free-running clock
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    task automatic results();
        if (failures == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : results
    task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic wait_n(input int n);
        repeat (n) @(posedge ref_clk);
    endtask : wait_n
    // query: wait a bounded time for the reply pulse, then read the reply register
    task automatic ask(input logic [CMD_W-1:0] code, input logic [DATA_W-1:0] exp);
        int k;
        k = 0;
        host.put(code, 8'h00);
        while (reply_valid !== 1'b1 && k < 8) begin
            @(negedge ref_clk);
            k++;
        end
        if (k == 8) begin
            failures++;
            results();
        end else begin
            host.get(OFS_REPLY, rv);
            check(rv, exp);
        end
    endtask : ask
    // condition pulse long enough to pass the input synchroniser, then a long quiet
    task automatic pulse(input logic [COND_W-1:0] v);
        cond_in <= v;
        wait_n(8);
        cond_in <= 8'h00;
        wait_n(16);
    endtask : pulse

    initial begin
        failures  = 0;
        n_checks  = 0;
        rstn      = 1'b0;
        remote_in = 1'b1;
        cond_in   = 8'h00;
        wait_n(16);
        rstn <= 1'b1;
        wait_n(1);
        check(pins, 16'h0003);
        cond_in <= 8'h5A;
        wait_n(8);
        ask(CMD_LIVE_Q, 16'h005A);
        ask(CMD_ACCUM_Q, 16'h005A);
        // old conditions stay high after the query, so they accumulate again
        pulse(8'h81);
        ask(CMD_LIVE_Q, 16'h0000);
        ask(CMD_ACCUM_Q, 16'h00DB);
        ask(CMD_ACCUM_Q, 16'h0000);
        ask(CMD_FAULT_Q, 16'h0000);
        host.put(CMD_ENABLE, 8'h0F);
        ask(CMD_ENABLE_Q, 16'h000F);
        host.put(CMD_BLOCK, 8'h03);
        ask(CMD_ENABLE_Q, 16'h000C);
        pulse(8'h36);
        check({15'h0, fault_out}, 16'h0001);
        ask(CMD_FAULT_Q, 16'h0004);
        wait_n(4);
        check({15'h0, fault_out}, 16'h0000);
        ask(CMD_FAULT_Q, 16'h0000);
        for (int i = 0; i < 4; i++) begin
            host.put(aux_cmd[i], aux_arg[i]);
            wait_n(3);
            check({14'h0, aux_two_n, aux_one_n}, aux_pin[i]);
            ask(aux_cmd[i] + 4'h1, {15'h0, aux_arg[i] != 8'h00});
        end
        host.put(CMD_CAL, 8'h01);
        wait_n(3);
        check({15'h0, cal_mode}, 16'h0001);
        ask(CMD_CAL_Q, 16'h0001);
        // restore in remote with a latched fault and an active aux output
        host.put(CMD_AUX1, 8'h01);
        pulse(8'h04);
        host.put(CMD_RESTORE, 8'h00);
        wait_n(3);
        check(pins, 16'h0007);
        ask(CMD_ENABLE_Q, 16'h0000);
        // restore in local waits for the switch to remote
        remote_in <= 1'b0;
        wait_n(8);
        host.put(CMD_AUX2, 8'h01);
        host.put(CMD_RESTORE, 8'h00);
        wait_n(8);
        check({15'h0, aux_two_n}, 16'h0000);
        host.get(OFS_STATE, rv);
        check(rv, 16'h000E);
        remote_in <= 1'b1;
        wait_n(8);
        check(pins, 16'h0007);
        host.put(CMD_CAL, 8'h00);
        ask(CMD_CAL_Q, 16'h0000);
        // an unknown code gives no reply, an unmapped read gives zero
        host.put(4'hE, 8'h00);
        repeat (3) begin
            @(negedge ref_clk);
            check({15'h0, reply_valid}, 16'h0000);
        end
        host.get(4'hF, rv);
        check(rv, 16'h0000);
        results();
    end
endmodule : testbench
